/* hw/wlu_map.svh */
// Purpose: register offsets, field positions, reset values of the wake-up line unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
`ifndef WLU_MAP_SVH
`define WLU_MAP_SVH
`define WLU_OFF_CONTROL 12'h000
`define WLU_OFF_MASK_LOW 12'h004
`define WLU_OFF_MASK_HIGH 12'h008
`define WLU_OFF_EDGE_LOW 12'h00C
`define WLU_OFF_EDGE_HIGH 12'h010
`define WLU_OFF_PEND_LOW 12'h014
`define WLU_OFF_PEND_HIGH 12'h018
`define WLU_OFF_STATUS 12'h01C
`define WLU_OFF_TOP 12'h020
`define WLU_BIT_WAKE_SEL 0
`define WLU_BIT_SRC_SEL 1
`define WLU_BIT_STOP 2
`define WLU_BIT_EXITED 0
`define WLU_BIT_IN_STOP 1
`define WLU_BIT_TL_TRIG 0
`define WLU_BIT_TL_PEND 1
`define WLU_BIT_TL_NM 2
`define WLU_BIT_TL_EN 3
`define WLU_BIT_TL_IEN 4
`define WLU_NUM_LINES 16
`define WLU_RST_CONTROL 3'h0
`define WLU_RESTART_NS 1000
`define WLU_RESTART_CYC ((`WLU_RESTART_NS + 7) / 8)
`endif

/* hw/wlu_pkg.sv */
// Purpose: types of the wake-up line unit
// Assumes: nothing
// Notes: constants live in wlu_map.svh
package wlu_pkg;
    typedef enum logic [1:0] {
        WLU_SEQ_IDLE,
        WLU_SEQ_ONE,
        WLU_SEQ_ZERO
    } wlu_seq_e;
    typedef enum logic [1:0] {
        WLU_PWR_RUN,
        WLU_PWR_STOP,
        WLU_PWR_RESTART
    } wlu_pwr_e;
    typedef struct packed {
        logic wake_sel;
        logic src_sel;
        logic stop;
    } wlu_ctrl_s;
    typedef struct packed {
        logic trig;
        logic nm;
        logic en;
        logic global_irq_enable;
    } wlu_top_s;
endpackage

/* hw/wlu_edge_detect.sv */
// Purpose: per-line programmable edge detector
// Assumes: lines synchronous to pclk
// Notes: one pulse per selected transition
`timescale 1ns/100ps
`include "wlu_map.svh"
module wlu_edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] lines,
    input wire logic [15:0] rising_sel,
    output logic [15:0] hit
);
    logic [15:0] prev_reg;
    logic [15:0] rise;
    logic [15:0] fall;
    assign rise = lines & ~prev_reg;
    assign fall = ~lines & prev_reg;
    assign hit = (rising_sel & rise) | (~rising_sel & fall); // [RULE_02]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 16'h0000;
        end else begin
            prev_reg <= lines;
        end
    end
endmodule

/* hw/wlu_top.sv */
// Purpose: wake-up line unit: 16 lines, stop sequence filter, top-level nmi flag
// Assumes: lines and nmi synchronous to pclk; registers over apb
// Notes: clock unit and cpu interrupt controller lie outside
// Overview of operation
// (RULE_01) sixteen extra lines, each an interrupt or a wake-up source.
// (RULE_02) each line has a programmable trigger edge.
// (RULE_03) each line has its own mask bit.
// (RULE_04) wake-select clear means interrupt mode, no wake-up.
// (RULE_05) source-select routes lines onto the shared channel.
// (RULE_06) wake-select set lets unmasked events end stop.
// (RULE_07) stop requested only by three writes 1,0,1.
// (RULE_08) acknowledged interrupt or dma rejects sequence; stop and exited read 0.
// (RULE_09) nmi edge exit leaves stop and exited at 1.
// (RULE_10) line wake-up exit clears stop bit in hardware.
// (RULE_11) nmi high at third write: stop 1, exited 0, no entry.
// (RULE_12) nmi falling afterwards does not enter stop.
// (RULE_13) nmi edge during sequence abandons entry, both bits 0.
// (RULE_14) line event during sequence abandons entry, pending set.
// (RULE_15) exited flag sticky until software clears it.
// (RULE_16) any unmasked line event ends stop after restart delay.
// (RULE_17) nmi rising edge also ends stop.
// (RULE_18) pending bits are edge set; clear holds until new edge.
// (RULE_19) trigger set: nmi edge sets top pending, request if nm or en&ien.
// (RULE_20) non-maskable bit cleared only by reset.
// (RULE_21) steady nmi high gives no entry and no new service.
// (RULE_22) nmi dropped before third write allows entry.
// (RULE_23) software enables the shared channel in the cpu.
// (RULE_24) wake-select bit readable.
// (RULE_25) interrupt mode raises channel only, no wake event.
// (RULE_26) entry needs no unmasked pending, a mask, wake-select, nmi low.
// (RULE_27) channel is or of unmasked pending; clearing one re-edges; the code keeps it high, no new edge, while another unmasked bit pends.
// (RULE_28) other register writes inside the sequence abort it.
`timescale 1ns/100ps
`include "wlu_map.svh"
module wlu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] wake_lines,
    input wire logic nmi,
    input wire logic irq_dma_ack,
    output logic shared_external_channel,
    output logic wake_event,
    output logic stop_request,
    output logic clock_run,
    output logic top_irq_request
);
    wlu_pkg::wlu_ctrl_s ctrl_reg;
    wlu_pkg::wlu_top_s top_reg;
    wlu_pkg::wlu_seq_e seq_reg;
    wlu_pkg::wlu_pwr_e pwr_reg;
    logic [15:0] mask_reg;
    logic [15:0] edge_reg;
    logic [15:0] pend_reg;
    logic [15:0] pend_next;
    logic exited_reg;
    logic top_pend_reg;
    logic nmi_prev_reg;
    logic nmi_hold_reg;
    logic [9:0] restart_cnt_reg;
    logic [15:0] line_hit;
    logic wr;
    logic rd;
    logic known;
    logic wr_ctrl;
    logic wr_stop_one;
    logic wr_stop_zero;
    logic nmi_rise;
    logic line_wake;
    logic wake_any;
    logic entry_ok;
    logic third_write;
    logic other_write;
    logic channel_next;
    logic [31:0] rdata_next;
    localparam logic [9:0] RESTART_LAST = 10'(`WLU_RESTART_CYC - 1);

    function automatic logic [15:0] wr_half(input logic [15:0] cur, input logic [7:0] d,
                                            input logic hi);
        wr_half = hi ? {d, cur[7:0]} : {cur[15:8], d};
    endfunction

    wlu_edge_detect u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .lines(wake_lines),
        .rising_sel(edge_reg),
        .hit(line_hit)
    );

    // zero-wait slave: one access cycle per transfer
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign known = (paddr <= `WLU_OFF_TOP) && (paddr[1:0] == 2'b00);
    assign wr_ctrl = wr && (paddr == `WLU_OFF_CONTROL);
    assign wr_stop_one = wr_ctrl && pwdata[`WLU_BIT_STOP];
    assign wr_stop_zero = wr_ctrl && !pwdata[`WLU_BIT_STOP];
    assign other_write = (wr && !wr_ctrl) || irq_dma_ack; // [RULE_28] [RULE_08]
    assign nmi_rise = nmi & ~nmi_prev_reg;
    // masked lines never wake; interrupt mode never wakes
    assign line_wake = ctrl_reg.wake_sel && |(line_hit & mask_reg); // [RULE_03] [RULE_04] [RULE_06]
    assign wake_any = line_wake || nmi_rise; // [RULE_16] [RULE_17]
    assign entry_ok = ctrl_reg.wake_sel && (mask_reg != 16'h0000)
        && ((pend_reg & mask_reg) == 16'h0000) && !nmi; // [RULE_26] [RULE_22]
    assign third_write = (seq_reg == wlu_pkg::WLU_SEQ_ZERO) && wr_stop_one && !other_write
        && !wake_any && !(|line_hit); // [RULE_07] [RULE_13] [RULE_14]
    // set wins over a clearing write in the same cycle
    assign pend_next = (wr && paddr == `WLU_OFF_PEND_LOW)
        ? wr_half(pend_reg, pwdata[7:0], 1'b0) & (pend_reg | line_hit)
        : (wr && paddr == `WLU_OFF_PEND_HIGH)
        ? wr_half(pend_reg, pwdata[7:0], 1'b1) & (pend_reg | line_hit)
        : pend_reg; // [RULE_18]
    assign channel_next = ctrl_reg.src_sel && |((pend_next | line_hit) & mask_reg); // [RULE_05] [RULE_25] [RULE_27]

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (paddr)
            `WLU_OFF_CONTROL: rdata_next[2:0] = {ctrl_reg.stop, ctrl_reg.src_sel, ctrl_reg.wake_sel}; // [RULE_24]
            `WLU_OFF_MASK_LOW: rdata_next[7:0] = mask_reg[7:0];
            `WLU_OFF_MASK_HIGH: rdata_next[7:0] = mask_reg[15:8];
            `WLU_OFF_EDGE_LOW: rdata_next[7:0] = edge_reg[7:0];
            `WLU_OFF_EDGE_HIGH: rdata_next[7:0] = edge_reg[15:8];
            `WLU_OFF_PEND_LOW: rdata_next[7:0] = pend_reg[7:0];
            `WLU_OFF_PEND_HIGH: rdata_next[7:0] = pend_reg[15:8];
            `WLU_OFF_STATUS: rdata_next[1:0] = {pwr_reg != wlu_pkg::WLU_PWR_RUN, exited_reg};
            `WLU_OFF_TOP: rdata_next[4:0] = {top_reg.global_irq_enable, top_reg.en, top_reg.nm, top_pend_reg, top_reg.trig};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            if (rd) begin
                prdata <= rdata_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= 16'h0000;
            edge_reg <= 16'h0000;
            pend_reg <= 16'h0000;
            nmi_prev_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi;
            pend_reg <= pend_next | line_hit; // [RULE_14] [RULE_18]
            if (wr && paddr == `WLU_OFF_MASK_LOW) begin
                mask_reg <= wr_half(mask_reg, pwdata[7:0], 1'b0);
            end
            if (wr && paddr == `WLU_OFF_MASK_HIGH) begin
                mask_reg <= wr_half(mask_reg, pwdata[7:0], 1'b1);
            end
            if (wr && paddr == `WLU_OFF_EDGE_LOW) begin
                edge_reg <= wr_half(edge_reg, pwdata[7:0], 1'b0);
            end
            if (wr && paddr == `WLU_OFF_EDGE_HIGH) begin
                edge_reg <= wr_half(edge_reg, pwdata[7:0], 1'b1);
            end
        end
    end

    // top-level nmi flag; pending set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_reg <= '0;
            top_pend_reg <= 1'b0;
        end else begin
            if (wr && paddr == `WLU_OFF_TOP) begin
                top_reg.trig <= pwdata[`WLU_BIT_TL_TRIG];
                top_reg.en <= pwdata[`WLU_BIT_TL_EN];
                top_reg.global_irq_enable <= pwdata[`WLU_BIT_TL_IEN];
                top_reg.nm <= top_reg.nm | pwdata[`WLU_BIT_TL_NM]; // [RULE_20]
            end
            if (top_reg.trig && nmi_rise) begin
                top_pend_reg <= 1'b1; // [RULE_19] [RULE_21]
            end else if (wr && paddr == `WLU_OFF_TOP && !pwdata[`WLU_BIT_TL_PEND]) begin
                top_pend_reg <= 1'b0;
            end
        end
    end

    // stop sequence recogniser and power state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `WLU_RST_CONTROL;
            seq_reg <= wlu_pkg::WLU_SEQ_IDLE;
            pwr_reg <= wlu_pkg::WLU_PWR_RUN;
            exited_reg <= 1'b0;
            nmi_hold_reg <= 1'b0;
            restart_cnt_reg <= 10'h000;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.wake_sel <= pwdata[`WLU_BIT_WAKE_SEL];
                ctrl_reg.src_sel <= pwdata[`WLU_BIT_SRC_SEL];
            end
            if (wr && paddr == `WLU_OFF_STATUS && !pwdata[`WLU_BIT_EXITED]) begin
                exited_reg <= 1'b0; // [RULE_15]
            end
            unique case (pwr_reg)
                wlu_pkg::WLU_PWR_RUN: begin
                    if (other_write || wake_any || |line_hit) begin
                        seq_reg <= wlu_pkg::WLU_SEQ_IDLE;
                        if (seq_reg != wlu_pkg::WLU_SEQ_IDLE) begin
                            ctrl_reg.stop <= 1'b0; // [RULE_08] [RULE_13] [RULE_28]
                        end
                    end else if (wr_stop_one && seq_reg == wlu_pkg::WLU_SEQ_IDLE
                                 && !nmi_hold_reg) begin
                        seq_reg <= wlu_pkg::WLU_SEQ_ONE;
                        ctrl_reg.stop <= 1'b1;
                    end else if (wr_stop_zero && seq_reg == wlu_pkg::WLU_SEQ_ONE) begin
                        seq_reg <= wlu_pkg::WLU_SEQ_ZERO;
                        ctrl_reg.stop <= 1'b0;
                    end else if (third_write) begin
                        seq_reg <= wlu_pkg::WLU_SEQ_IDLE;
                        if (entry_ok) begin
                            ctrl_reg.stop <= 1'b1;
                            pwr_reg <= wlu_pkg::WLU_PWR_STOP;
                        end else if (nmi) begin
                            ctrl_reg.stop <= 1'b1; // [RULE_11]
                            nmi_hold_reg <= 1'b1; // [RULE_12]
                        end else begin
                            ctrl_reg.stop <= 1'b0;
                        end
                    end else if (wr_ctrl) begin
                        seq_reg <= wlu_pkg::WLU_SEQ_IDLE;
                        ctrl_reg.stop <= 1'b0;
                        nmi_hold_reg <= 1'b0;
                    end
                end
                wlu_pkg::WLU_PWR_STOP: begin
                    if (nmi_rise) begin
                        exited_reg <= 1'b1; // [RULE_09] [RULE_17]
                        pwr_reg <= wlu_pkg::WLU_PWR_RESTART;
                        restart_cnt_reg <= 10'h000;
                    end else if (line_wake) begin
                        exited_reg <= 1'b1;
                        ctrl_reg.stop <= 1'b0; // [RULE_10]
                        pwr_reg <= wlu_pkg::WLU_PWR_RESTART;
                        restart_cnt_reg <= 10'h000;
                    end
                end
                wlu_pkg::WLU_PWR_RESTART: begin
                    if (restart_cnt_reg == RESTART_LAST) begin
                        pwr_reg <= wlu_pkg::WLU_PWR_RUN; // [RULE_16]
                    end else begin
                        restart_cnt_reg <= restart_cnt_reg + 10'h001;
                    end
                end
                default: pwr_reg <= wlu_pkg::WLU_PWR_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_external_channel <= 1'b0;
            wake_event <= 1'b0;
            stop_request <= 1'b0;
            clock_run <= 1'b1;
            top_irq_request <= 1'b0;
        end else begin
            shared_external_channel <= channel_next; // [RULE_27]
            wake_event <= (pwr_reg == wlu_pkg::WLU_PWR_STOP) && wake_any;
            stop_request <= (pwr_reg == wlu_pkg::WLU_PWR_STOP);
            clock_run <= (pwr_reg == wlu_pkg::WLU_PWR_RUN);
            top_irq_request <= (top_pend_reg | (top_reg.trig & nmi_rise))
                & (top_reg.nm | (top_reg.en & top_reg.global_irq_enable)); // [RULE_19]
        end
    end
endmodule

/* dv/wlu_top_assertions.sv */
// Purpose: port checks of wlu_top
// Assumes: one clock domain, zero-wait apb access
// Notes: restart window brackets the 125-cycle delay
`timescale 1ns/100ps
`include "wlu_map.svh"
module wlu_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nmi,
    input wire logic wake_event,
    input wire logic stop_request,
    input wire logic clock_run
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire ctl_wr = psel && penable && pwrite && (paddr == `WLU_OFF_CONTROL);
    wire stop_one = pwdata[`WLU_BIT_STOP];
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ENTRY_CAUSE: assert property ($rose(stop_request) |-> $past(ctl_wr && stop_one && !nmi, 2))
        else $error("stop entered without a 1 write and nmi low");
    AST_ENTRY_STOPS_CLOCK: assert property ($rose(stop_request) |-> !clock_run)
        else $error("clock still running in stop");
    AST_WAKE_IN_STOP: assert property (wake_event |-> $past(stop_request))
        else $error("wake event outside stop");
    AST_WAKE_PULSE: assert property (wake_event |=> !wake_event)
        else $error("wake event longer than a cycle");
    AST_NMI_WAKES: assert property (stop_request && $rose(nmi) |-> ##[1:2] wake_event)
        else $error("nmi edge did not wake");
    AST_WAKE_ENDS_STOP: assert property (wake_event |-> ##[0:2] !stop_request)
        else $error("stop held after wake");
    AST_RESTART_HOLD: assert property ($rose(wake_event) |-> !clock_run [*8])
        else $error("clock restarted too early");
    AST_RESTART_END: assert property ($rose(wake_event) |-> ##[100:140] clock_run)
        else $error("clock did not restart");
endmodule
bind wlu_top wlu_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .nmi(nmi), .wake_event(wake_event), .stop_request(stop_request),
    .clock_run(clock_run));

/* dv/wlu_line_source.sv */
// Purpose: external line, nmi and acknowledge source
// Assumes: sources change just after a rising edge
// Notes: levels are held until told otherwise
`timescale 1ns/100ps
module wlu_line_source (
    input wire logic pclk,
    output logic [15:0] wake_lines,
    output logic nmi,
    output logic irq_dma_ack
);
    initial begin
        wake_lines = 16'h0000;
        nmi = 1'b0;
        irq_dma_ack = 1'b0;
    end
    task automatic set_line(input int idx, input logic val);
        @(posedge pclk);
        wake_lines[idx] <= val;
    endtask
    task automatic set_nmi(input logic val);
        @(posedge pclk);
        nmi <= val;
    endtask
    // one-cycle acknowledge, as the cpu gives it
    task automatic ack_pulse();
        @(posedge pclk);
        irq_dma_ack <= 1'b1;
        @(posedge pclk);
        irq_dma_ack <= 1'b0;
    endtask
endmodule

/* dv/test_wakeup_interrupt_line_unit.sv */
// Purpose: directed tests of wlu_top over apb
// Assumes: zero-wait apb, 125 MHz pclk
// Notes: expectations from the register map only
`timescale 1ns/100ps
`include "wlu_map.svh"
module test_wakeup_interrupt_line_unit;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] wake_lines;
    logic nmi, irq_dma_ack, chan, wake_ev, stop_req, clk_run, top_irq, rerr;
    int err_count, total_checks;
    wlu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_lines(wake_lines), .nmi(nmi), .irq_dma_ack(irq_dma_ack),
        .shared_external_channel(chan), .wake_event(wake_ev), .stop_request(stop_req),
        .clock_run(clk_run), .top_irq_request(top_irq));
    wlu_line_source src (.pclk(pclk), .wake_lines(wake_lines), .nmi(nmi),
        .irq_dma_ack(irq_dma_ack));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // sample mid-cycle; the answer stands until the next rising edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chkb(pready, 1'b1);
        rd = prdata;
        rerr = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // waits are bounded so a missing wake shows up as a mismatch
    task automatic wait_wake_and_run();
        int n;
        n = 0;
        while (wake_ev !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chkb(wake_ev, 1'b1);
        n = 0;
        while (clk_run !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chkb(clk_run, 1'b1);
    endtask
    task automatic stop_seq();
        wr(`WLU_OFF_CONTROL, 32'h07);
        wr(`WLU_OFF_CONTROL, 32'h03);
        wr(`WLU_OFF_CONTROL, 32'h07);
        cyc(2);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #(8 * 20000);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_count = 0;
        total_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`WLU_OFF_CONTROL, 32'h00);
        wr(`WLU_OFF_MASK_LOW, 32'h01);
        wr(`WLU_OFF_EDGE_LOW, 32'h05);
        wr(`WLU_OFF_CONTROL, 32'h02);
        src.set_line(0, 1'b1);
        src.set_line(1, 1'b1);
        src.set_line(2, 1'b1);
        cyc(4);
        rchk(`WLU_OFF_PEND_LOW, 32'h05);
        chkb(chan, 1'b1);
        chkb(stop_req, 1'b0);
        wr(`WLU_OFF_PEND_LOW, 32'h04);
        cyc(4);
        rchk(`WLU_OFF_PEND_LOW, 32'h04);
        chkb(chan, 1'b0);
        wr(`WLU_OFF_MASK_LOW, 32'h05);
        cyc(3);
        chkb(chan, 1'b1);
        wr(`WLU_OFF_PEND_LOW, 32'h00);
        src.set_line(0, 1'b0);
        src.set_line(1, 1'b0);
        src.set_line(2, 1'b0);
        cyc(4);
        rchk(`WLU_OFF_PEND_LOW, 32'h02);
        apb(1'b0, 12'h040, 32'h0);
        chk(rd, 32'h0);
        chkb(rerr, 1'b1);
        $display("interrupt mode test done");
        wr(`WLU_OFF_PEND_LOW, 32'h00);
        wr(`WLU_OFF_CONTROL, 32'h03);
        stop_seq();
        chkb(stop_req, 1'b1);
        chkb(clk_run, 1'b0);
        src.set_line(0, 1'b1);
        wait_wake_and_run();
        rchk(`WLU_OFF_CONTROL, 32'h03);
        rchk(`WLU_OFF_STATUS, 32'h01);
        rchk(`WLU_OFF_PEND_LOW, 32'h01);
        wr(`WLU_OFF_STATUS, 32'h00);
        rchk(`WLU_OFF_STATUS, 32'h00);
        wr(`WLU_OFF_PEND_LOW, 32'h00);
        src.set_line(0, 1'b0);
        $display("line wake test done");
        stop_seq();
        src.set_nmi(1'b1);
        wait_wake_and_run();
        rchk(`WLU_OFF_CONTROL, 32'h07);
        rchk(`WLU_OFF_STATUS, 32'h01);
        wr(`WLU_OFF_CONTROL, 32'h03);
        wr(`WLU_OFF_STATUS, 32'h00);
        stop_seq();
        chkb(stop_req, 1'b0);
        rchk(`WLU_OFF_CONTROL, 32'h07);
        rchk(`WLU_OFF_STATUS, 32'h00);
        src.set_nmi(1'b0);
        cyc(4);
        chkb(stop_req, 1'b0);
        wr(`WLU_OFF_CONTROL, 32'h03);
        src.set_nmi(1'b1);
        wr(`WLU_OFF_CONTROL, 32'h07);
        wr(`WLU_OFF_CONTROL, 32'h03);
        src.set_nmi(1'b0);
        wr(`WLU_OFF_CONTROL, 32'h07);
        cyc(2);
        chkb(stop_req, 1'b1);
        src.set_line(0, 1'b1);
        wait_wake_and_run();
        wr(`WLU_OFF_PEND_LOW, 32'h00);
        wr(`WLU_OFF_STATUS, 32'h00);
        src.set_line(0, 1'b0);
        $display("nmi test done");
        for (int k = 0; k < 4; k++) begin
            wr(`WLU_OFF_CONTROL, 32'h07);
            case (k)
                0: src.ack_pulse();
                1: src.set_nmi(1'b1);
                2: src.set_line(0, 1'b1);
                default: wr(`WLU_OFF_EDGE_HIGH, 32'h00);
            endcase
            cyc(2);
            rchk(`WLU_OFF_CONTROL, 32'h03);
            wr(`WLU_OFF_CONTROL, 32'h03);
            wr(`WLU_OFF_CONTROL, 32'h07);
            cyc(2);
            chkb(stop_req, 1'b0);
            rchk(`WLU_OFF_STATUS, 32'h00);
            src.set_nmi(1'b0);
            src.set_line(0, 1'b0);
            wr(`WLU_OFF_PEND_LOW, 32'h00);
            wr(`WLU_OFF_CONTROL, 32'h03);
        end
        $display("abort test done");
        wr(`WLU_OFF_TOP, 32'h19);
        src.set_nmi(1'b1);
        cyc(3);
        chkb(top_irq, 1'b1);
        wr(`WLU_OFF_TOP, 32'h11);
        src.set_nmi(1'b0);
        src.set_nmi(1'b1);
        cyc(3);
        chkb(top_irq, 1'b0);
        rchk(`WLU_OFF_TOP, 32'h13);
        wr(`WLU_OFF_TOP, 32'h05);
        wr(`WLU_OFF_TOP, 32'h01);
        rchk(`WLU_OFF_TOP, 32'h05);
        $display("top level test done");
        wr(`WLU_OFF_MASK_HIGH, 32'h80);
        wr(`WLU_OFF_EDGE_HIGH, 32'h00);
        wr(`WLU_OFF_CONTROL, 32'h02);
        src.set_line(15, 1'b1);
        src.set_line(15, 1'b0);
        cyc(4);
        rchk(`WLU_OFF_PEND_HIGH, 32'h80);
        chkb(chan, 1'b1);
        rchk(`WLU_OFF_MASK_HIGH, 32'h80);
        $display("high line test done");
        print_verdict();
    end
endmodule
